// >>> hdl/edsc_bank.sv
// apb register bank for emitter drive codes, slot masks and settle delay
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] emitter 1 code is six bits
// [RULE_02] emitter 2 code is seven bits
// [RULE_03] emitter 3 code is seven bits
// [RULE_04] separate codes per sequencer, active set applied
// [RULE_05] mask bits select emitters one to three
// [RULE_06] zero mask drives none, ones drive all
// [RULE_07] sequencer a: eight slots, two per register
// [RULE_08] sequencer b: four slots in two registers
// [RULE_09] turn-on waits code microseconds before monitoring
// [RULE_10] masked emitters use active sequencer code
// [RULE_11] unused bits ignore writes, read zero
module edsc_bank import edsc_pkg::*; #(
   parameter int unsigned ADDR_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sequencer timing
   input wire logic slot_valid,
   input wire edsc_seq_t seq_sel,
   input wire logic [2:0] slot_idx,
   // emitter drive
   output edsc_drive_t drive_r,
   output logic monitor_start
);

   // the index must fit eight bits without aliasing
   if (ADDR_W < 8 || ADDR_W > 10) begin : g_bad
      $error("edsc_bank: ADDR_W must be 8 to 10");
   end

   // stored configuration
   logic [6:0] code_r [3][2]; // emitter by sequencer
   logic [MASK_W-1:0] mask_r [SLOTS_A + SLOTS_B]; // a slots then b slots
   logic [7:0] wait_r; // settle delay code

   // bus side
   logic [31:0] prdata_r; // read data flop
   logic pready_r; // ready flop
   logic pslverr_r; // error flop
   logic [7:0] idx; // register index
   logic [7:0] off_c; // offset in code range
   logic [7:0] off_m; // offset in mask range
   logic [7:0] rd_val; // selected read value
   logic hit; // mapped and aligned
   logic setup; // first cycle of a transfer
   logic wr_en; // write commit edge

   // drive side
   edsc_drive_t drive_nxt; // next drive set
   logic slot_ok; // slot exists for this sequencer
   logic [MASK_W-1:0] msk; // mask of current slot
   logic [3:0] slot_pos; // slot position in mask_r
   logic seq_i; // sequencer as index
   logic turn_on; // some emitter switches on
   logic timer_done; // settle delay expired

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // index from the word address, byte lanes below are ignored
   assign idx = 8'(paddr >> 2);
   assign off_c = idx - IDX_SEQ_A_EMITTER1_DRIVE;
   assign off_m = idx - IDX_SEQ_A_SLOTS_1_2_MASK;
   assign setup = psel && !penable;
   // commit only at the edge where ready is seen
   assign wr_en = psel && penable && pready_r && pwrite && hit && pstrb[0];

   // address decode and read value
   always_comb begin
      hit = (paddr[1:0] == 2'b00);
      rd_val = 8'h00;
      if (idx >= IDX_SEQ_A_EMITTER1_DRIVE && idx <= IDX_SEQ_B_EMITTER3_DRIVE) begin
         // upper bit of emitter 1 code is always zero
         rd_val = {1'b0, code_r[off_c[2:1]][off_c[0]]}; // RULE_04
      end else if (idx >= IDX_SEQ_A_SLOTS_1_2_MASK && idx <= IDX_SEQ_B_SLOTS_3_4_MASK) begin
         // odd slot high, following even slot low
         rd_val = {1'b0, mask_r[{off_m[2:0], 1'b0}], 1'b0,
                   mask_r[{off_m[2:0], 1'b1}]}; // RULE_07
      end else if (idx == IDX_SUPPLY_MONITOR_DELAY) begin
         rd_val = wait_r;
      end else begin
         hit = 1'b0; // unmapped index
      end
   end

   // ready comes one cycle after setup, so every access has one wait-free access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= setup;
      end
   end

   // read data and error captured in setup, upper bits zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         // refused reads give zero, a misaligned address would alias a live register
         prdata_r <= (pwrite || !hit) ? 32'h00000000 : {24'h000000, rd_val}; // RULE_11
         pslverr_r <= !hit;
      end else if (pready_r) begin
         pslverr_r <= 1'b0;
      end
   end

   // drive code registers, one per emitter and sequencer
   for (genvar e = 0; e < 3; e++) begin : g_emit
      for (genvar s = 0; s < 2; s++) begin : g_seq
         localparam logic [7:0] MY_IDX = IDX_SEQ_A_EMITTER1_DRIVE + 8'(2 * e + s);
         localparam logic [6:0] KEEP = (e == 0) ? CODE1_KEEP : CODE23_KEEP;
         // each set is written on its own index only
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               code_r[e][s] <= RST_REG[6:0];
            end else if (wr_en && idx == MY_IDX) begin
               code_r[e][s] <= pwdata[6:0] & KEEP; // RULE_01 RULE_02 RULE_03 RULE_04
            end
         end
      end
   end

   // slot mask registers, two slots in each
   for (genvar p = 0; p < MASK_PAIRS; p++) begin : g_pair
      localparam logic [7:0] MY_IDX = IDX_SEQ_A_SLOTS_1_2_MASK + 8'(p);
      // bits 7 and 3 are dropped
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mask_r[2 * p] <= RST_REG[MASK_W-1:0];
            mask_r[2 * p + 1] <= RST_REG[MASK_W-1:0];
         end else if (wr_en && idx == MY_IDX) begin
            mask_r[2 * p] <= pwdata[MASK_ODD_LSB +: MASK_W]; // RULE_07 RULE_08
            mask_r[2 * p + 1] <= pwdata[MASK_EVEN_LSB +: MASK_W]; // RULE_07 RULE_08
         end
      end
   end

   // settle delay code
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_r <= RST_REG;
      end else if (wr_en && idx == IDX_SUPPLY_MONITOR_DELAY) begin
         wait_r <= pwdata[7:0];
      end
   end

   // choose the current slot mask
   always_comb begin
      seq_i = (seq_sel == EDSC_SEQ_B);
      // sequencer b has only four slots
      slot_ok = slot_valid && (!seq_i || slot_idx < 3'(SLOTS_B)); // RULE_08
      slot_pos = seq_i ? 4'({1'b0, slot_idx} + 4'(SLOTS_A)) : {1'b0, slot_idx};
      msk = mask_r[slot_pos];
      drive_nxt = '0;
      if (slot_ok) begin
         drive_nxt.on = msk; // RULE_05 RULE_06
         // a clear bit keeps that emitter at code zero and off
         if (msk[0]) begin
            drive_nxt.code1 = code_r[0][seq_i][5:0]; // RULE_10 RULE_01
         end
         if (msk[1]) begin
            drive_nxt.code2 = code_r[1][seq_i]; // RULE_10 RULE_02
         end
         if (msk[2]) begin
            drive_nxt.code3 = code_r[2][seq_i]; // RULE_10 RULE_03
         end
      end
   end

   // registered drive set to the analog side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_r <= '0;
      end else begin
         drive_r <= drive_nxt; // RULE_04 RULE_10
      end
   end

   // only an emitter going from off to on restarts the settle wait
   assign turn_on = |(drive_nxt.on & ~drive_r.on);

   // settle timer, its done output is a flop
   edsc_settle_timer #(
      .STEPS(STEP_CYC),
      .WAIT_W(8)
   ) u_settle (
      .pclk(pclk),
      .presetn(presetn),
      .start_i(turn_on), // RULE_09
      .cancel_i(drive_nxt.on == 3'b000),
      .delay_i(wait_r),
      .done_r(timer_done)
   );

   assign monitor_start = timer_done;

   // checks

   chk_apb_ready: assert property (
      @(posedge pclk) disable iff (!presetn)
      setup |=> pready_r ##1 !pready_r)
      else $error("ready not one cycle after setup");

   chk_code1_six_bits: assert property ( // RULE_01
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_A_EMITTER1_DRIVE)
      |=> code_r[0][0] == {1'b0, $past(pwdata[5:0])})
      else $error("emitter 1 code not six bits");

   chk_code2_seven_bits: assert property ( // RULE_02
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_A_EMITTER2_DRIVE) |=> code_r[1][0] == $past(pwdata[6:0]))
      else $error("emitter 2 code not stored");

   chk_code3_seven_bits: assert property ( // RULE_03
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_B_EMITTER3_DRIVE) |=> code_r[2][1] == $past(pwdata[6:0]))
      else $error("emitter 3 code not stored");

   chk_seq_sets_apart: assert property ( // RULE_04
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_A_EMITTER1_DRIVE) |=> $stable(code_r[0][1]))
      else $error("sequencer b code disturbed");

   chk_mask_selects: assert property ( // RULE_05
      @(posedge pclk) disable iff (!presetn)
      (slot_valid && seq_sel == EDSC_SEQ_A) |=> drive_r.on == $past(mask_r[slot_idx]))
      else $error("emitters differ from slot mask");

   chk_zero_mask_off: assert property ( // RULE_06
      @(posedge pclk) disable iff (!presetn)
      (!slot_ok || msk == 3'b000) |=> drive_r == '0)
      else $error("emitter driven with empty mask");

   chk_pair_layout: assert property ( // RULE_07
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_A_SLOTS_1_2_MASK)
      |=> mask_r[0] == $past(pwdata[6:4]) && mask_r[1] == $past(pwdata[2:0]))
      else $error("slot pair layout wrong");

   chk_seq_b_slots: assert property ( // RULE_08
      @(posedge pclk) disable iff (!presetn)
      (slot_valid && seq_sel == EDSC_SEQ_B && slot_idx == 3'd3)
      |=> drive_r.on == $past(mask_r[SLOTS_A + 3]))
      else $error("sequencer b slot 4 mask wrong");

   chk_zero_wait: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      (turn_on && wait_r == 8'h00) |=> monitor_start)
      else $error("zero wait not immediate");

   chk_active_code: assert property ( // RULE_10
      @(posedge pclk) disable iff (!presetn)
      (slot_ok && msk[2]) |=> drive_r.code3 == $past(code_r[2][seq_i]))
      else $error("emitter 3 code not from active sequencer");

   chk_read_upper_zero: assert property ( // RULE_11
      @(posedge pclk) disable iff (!presetn)
      (setup && !hit) |=> prdata_r == 32'h00000000 && pslverr_r)
      else $error("unmapped read not zero with error");

   chk_code1_seq_b: assert property ( // RULE_01
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_B_EMITTER1_DRIVE)
      |=> code_r[0][1] == {1'b0, $past(pwdata[5:0])})
      else $error("sequencer b emitter 1 code not six bits");

   chk_code2_seq_b: assert property ( // RULE_02
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_B_EMITTER2_DRIVE) |=> code_r[1][1] == $past(pwdata[6:0]))
      else $error("sequencer b emitter 2 code not stored");

   chk_code3_seq_a: assert property ( // RULE_03
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SEQ_A_EMITTER3_DRIVE) |=> code_r[2][0] == $past(pwdata[6:0]))
      else $error("sequencer a emitter 3 code not stored");

   chk_all_ones_mask: assert property ( // RULE_06
      @(posedge pclk) disable iff (!presetn)
      (slot_ok && msk == 3'b111) |=> drive_r.on == 3'b111)
      else $error("full mask does not drive all emitters");

   chk_seq_b_upper_off: assert property ( // RULE_08
      @(posedge pclk) disable iff (!presetn)
      (slot_valid && seq_sel == EDSC_SEQ_B && slot_idx >= 3'(SLOTS_B)) |=> drive_r == '0)
      else $error("sequencer b slot beyond four drives an emitter");

   chk_delay_stored: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      (wr_en && idx == IDX_SUPPLY_MONITOR_DELAY) |=> wait_r == $past(pwdata[7:0]))
      else $error("settle delay code not stored");

   chk_delay_read: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr[1:0] == 2'b00 && idx == IDX_SUPPLY_MONITOR_DELAY)
      |=> prdata_r == {24'h000000, $past(wait_r)})
      else $error("settle delay code reads back wrong");

   chk_no_early_start: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      (turn_on && wait_r != 8'h00) |=> !monitor_start)
      else $error("monitor started before the settle wait");

   chk_strobe_gate: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && pready_r && pwrite && !pstrb[0]) |=> $stable(wait_r))
      else $error("write without low strobe changed the delay");

   chk_active_code1: assert property ( // RULE_10
      @(posedge pclk) disable iff (!presetn)
      (slot_ok && msk[0]) |=> drive_r.code1 == $past(code_r[0][seq_i][5:0]))
      else $error("emitter 1 code not from active sequencer");

   chk_active_code2: assert property ( // RULE_10
      @(posedge pclk) disable iff (!presetn)
      (slot_ok && msk[1]) |=> drive_r.code2 == $past(code_r[1][seq_i]))
      else $error("emitter 2 code not from active sequencer");

   chk_off_code_zero: assert property ( // RULE_10
      @(posedge pclk) disable iff (!presetn)
      (slot_ok && !msk[1]) |=> drive_r.code2 == 7'h00)
      else $error("unmasked emitter 2 carries a code");

   chk_error_with_ready: assert property (
      @(posedge pclk) disable iff (!presetn)
      pslverr_r |-> pready_r)
      else $error("error shown outside the access cycle");

   chk_upper_bits_zero: assert property ( // RULE_11
      @(posedge pclk) disable iff (!presetn)
      prdata_r[31:8] == 24'h000000)
      else $error("read data upper bits not zero");

endmodule : edsc_bank

// >>> include/edsc_pkg.sv
// shared constants and types of the emitter drive configuration bank
package edsc_pkg;

   // clock and time base
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned STEP_NS = 1000;
   // cycles per delay step, least time so rounded up
   localparam int unsigned STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_SEQ_A_EMITTER1_DRIVE = 8'h29;
   localparam logic [7:0] IDX_SEQ_B_EMITTER1_DRIVE = 8'h2a;
   localparam logic [7:0] IDX_SEQ_A_EMITTER2_DRIVE = 8'h2b;
   localparam logic [7:0] IDX_SEQ_B_EMITTER2_DRIVE = 8'h2c;
   localparam logic [7:0] IDX_SEQ_A_EMITTER3_DRIVE = 8'h2d;
   localparam logic [7:0] IDX_SEQ_B_EMITTER3_DRIVE = 8'h2e;
   localparam logic [7:0] IDX_SEQ_A_SLOTS_1_2_MASK = 8'h2f;
   localparam logic [7:0] IDX_SEQ_A_SLOTS_3_4_MASK = 8'h30;
   localparam logic [7:0] IDX_SEQ_A_SLOTS_5_6_MASK = 8'h31;
   localparam logic [7:0] IDX_SEQ_A_SLOTS_7_8_MASK = 8'h32;
   localparam logic [7:0] IDX_SEQ_B_SLOTS_1_2_MASK = 8'h33;
   localparam logic [7:0] IDX_SEQ_B_SLOTS_3_4_MASK = 8'h34;
   localparam logic [7:0] IDX_SUPPLY_MONITOR_DELAY = 8'h35;

   // field layout
   localparam int unsigned MASK_W = 3;
   localparam int unsigned MASK_ODD_LSB = 4;
   localparam int unsigned MASK_EVEN_LSB = 0;
   localparam logic [6:0] CODE1_KEEP = 7'h3f;
   localparam logic [6:0] CODE23_KEEP = 7'h7f;

   // reset values
   localparam logic [7:0] RST_REG = 8'h00;

   // slot counts
   localparam int unsigned SLOTS_A = 8;
   localparam int unsigned SLOTS_B = 4;
   localparam int unsigned MASK_PAIRS = (SLOTS_A + SLOTS_B) / 2;

   // which sequencer runs
   typedef enum logic {EDSC_SEQ_A, EDSC_SEQ_B} edsc_seq_t;

   // drive set handed to the analog emitter drivers
   typedef struct packed {
      logic [2:0] on;
      logic [5:0] code1;
      logic [6:0] code2;
      logic [6:0] code3;
   } edsc_drive_t;

   // settle timer states
   typedef enum logic {EDSC_T_IDLE, EDSC_T_WAIT} edsc_tstate_t;

endpackage : edsc_pkg

// >>> hdl/edsc_settle_timer.sv
// settle delay between emitter turn-on and supply monitoring start
`timescale 1ns/1ps
module edsc_settle_timer import edsc_pkg::*; #(
   parameter int unsigned STEPS = STEP_CYC,
   parameter int unsigned WAIT_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic start_i,
   input wire logic cancel_i,
   input wire logic [WAIT_W-1:0] delay_i,
   // result
   output logic done_r
);

   // refuse shapes the counters cannot hold
   if (STEPS < 1 || STEPS > 65535 || WAIT_W < 1 || WAIT_W > 16) begin : g_bad
      $error("edsc_settle_timer: unsupported STEPS or WAIT_W");
   end

   edsc_tstate_t state_r; // timer state
   logic [15:0] div_r; // cycles inside the current step
   logic [WAIT_W-1:0] remain_r; // steps still to wait
   logic tick; // one-cycle step enable from the divider

   // divider reaches end of step
   assign tick = (state_r == EDSC_T_WAIT) && (div_r == 16'(STEPS - 1));

   // restart wins over cancel so a fresh turn-on is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= EDSC_T_IDLE;
         div_r <= 16'h0000;
         remain_r <= '0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start_i) begin
            div_r <= 16'h0000;
            remain_r <= delay_i;
            if (delay_i == '0) begin
               done_r <= 1'b1; // zero code, no wait [RULE_09]
               state_r <= EDSC_T_IDLE;
            end else begin
               state_r <= EDSC_T_WAIT;
            end
         end else if (cancel_i) begin
            state_r <= EDSC_T_IDLE; // emitters off, nothing to monitor
         end else begin
            case (state_r)
               EDSC_T_IDLE: begin
                  div_r <= 16'h0000;
               end
               EDSC_T_WAIT: begin
                  if (tick) begin
                     div_r <= 16'h0000;
                     if (remain_r == WAIT_W'(1)) begin
                        done_r <= 1'b1; // whole steps elapsed [RULE_09]
                        state_r <= EDSC_T_IDLE;
                     end else begin
                        remain_r <= remain_r - WAIT_W'(1);
                     end
                  end else begin
                     div_r <= div_r + 16'h0001;
                  end
               end
               default: state_r <= EDSC_T_IDLE;
            endcase
         end
      end
   end

   // helper: cycles since the last start and the delay then taken
   logic [23:0] elapsed_r;
   logic [WAIT_W-1:0] dly_l_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         elapsed_r <= 24'h000000;
         dly_l_r <= '0;
      end else if (start_i) begin
         elapsed_r <= 24'h000001;
         dly_l_r <= delay_i;
      end else if (elapsed_r != 24'hffffff) begin
         elapsed_r <= elapsed_r + 24'h000001;
      end
   end

   chk_settle_exact: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      done_r |-> elapsed_r == 24'(1 + dly_l_r * STEPS))
      else $error("settle delay length wrong");

endmodule : edsc_settle_timer

// >>> tb/edsc_bank_tb.sv
// self-checking bench for the emitter drive configuration bank
`timescale 1ns/1ps
module edsc_bank_tb import edsc_pkg::*;;
   // clock and reset
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   // apb master side
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // sequencer timing stimulus
   logic slot_valid = 1'b0;
   edsc_seq_t seq_sel = EDSC_SEQ_A;
   logic [2:0] slot_idx = 3'h0;
   // emitter drive results
   edsc_drive_t drive_r;
   logic monitor_start;
   // bookkeeping and last bus answer
   int err_count = 0;
   int n_tests = 0;
   logic [31:0] rd;
   logic err;
   int hit;
   // codes a/e1, b/e1, a/e2, b/e2, a/e3, b/e3, then the six slot pair masks
   logic [7:0] cfg [12] = '{8'h15, 8'h2b, 8'h2a, 8'h11, 8'h55, 8'h7f,
                            8'h01, 8'h23, 8'h45, 8'h67, 8'h76, 8'h54};
   // unmapped below, unmapped above, misaligned
   logic [7:0] bad [3] = '{8'ha0, 8'hd8, 8'ha5};

   // 40 mhz clock
   always #12.5 pclk = ~pclk;

   edsc_bank #(.ADDR_W(8)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .slot_valid(slot_valid), .seq_sel(seq_sel), .slot_idx(slot_idx),
      .drive_r(drive_r), .monitor_start(monitor_start)
   );

   // verdict and end of run
   task end_of_test;
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   // register or bus word comparison
   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   // drive set comparison
   task chk_drv(input edsc_drive_t got, input edsc_drive_t exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_drv

   // cycle count comparison, -1 means no pulse seen
   task chk_cyc(input int got, input int exp);
      n_tests++;
      if (got != exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_cyc

   // byte address of the i-th register counted from the first one
   function automatic logic [7:0] ba(input int i);
      return 8'((8'h29 + i) * 4);
   endfunction : ba

   // bits that survive a write of all ones
   function automatic logic [31:0] keep(input int i);
      if (i < 2) return 32'h3f;
      if (i < 6) return 32'h7f;
      if (i < 12) return 32'h77;
      return 32'hff;
   endfunction : keep

   // expected drive set: masked-off emitters carry code zero
   function automatic edsc_drive_t exp_drv(input logic [2:0] m, input int q);
      edsc_drive_t e;
      e.on = m;
      e.code1 = m[0] ? cfg[q][5:0] : 6'h00;
      e.code2 = m[1] ? cfg[2 + q][6:0] : 7'h00;
      e.code3 = m[2] ? cfg[4 + q][6:0] : 7'h00;
      return e;
   endfunction : exp_drv

   // one apb transfer, held until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait count assumed, a hang is ended by the watchdog
      do @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // turn all emitters on, record the cycle of the monitor pulse
   task watch(input int lim, input int cut);
      int k;
      hit = -1;
      @(posedge pclk);
      slot_valid <= 1'b1;
      seq_sel <= EDSC_SEQ_A;
      slot_idx <= 3'h7;
      for (k = 0; k < lim; k++) begin
         @(negedge pclk);
         if (monitor_start === 1'b1 && hit < 0) hit = k;
         @(posedge pclk);
         if (k + 1 == cut) slot_valid <= 1'b0;
      end
      slot_valid <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : watch

   // main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         apb(1'b0, ba(i), 32'h0, 4'h0);
         chk_reg({err, rd[30:0]}, 32'h0);
         apb(1'b1, ba(i), 32'hffffffff, 4'hf);
         apb(1'b0, ba(i), 32'h0, 4'h0);
         chk_reg(rd, keep(i));
      end
      // write without the low strobe leaves the delay untouched
      apb(1'b1, ba(12), 32'h12, 4'he);
      apb(1'b0, ba(12), 32'h0, 4'h0);
      chk_reg(rd, 32'hff);
      // unmapped and misaligned places answer with an error and zero
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, bad[i], 32'hffffffff, 4'hf);
         chk_reg({31'h0, err}, 32'h1);
         apb(1'b0, bad[i], 32'h0, 4'h0);
         chk_reg({err, rd[30:0]}, 32'h80000000);
      end
      // load distinct codes per sequencer and every mask combination
      for (int i = 0; i < 12; i++) begin
         apb(1'b1, ba(i), {24'h0, cfg[i]}, 4'h1);
      end
      for (int q = 0; q < 2; q++) begin
         for (int s = 0; s < 8; s++) begin
            @(posedge pclk);
            slot_valid <= 1'b1;
            seq_sel <= edsc_seq_t'(q);
            slot_idx <= 3'(s);
            @(posedge pclk);
            @(negedge pclk);
            if (q == 0) chk_drv(drive_r, exp_drv(3'(s), 0));
            else chk_drv(drive_r, exp_drv(s < 4 ? 3'(7 - s) : 3'h0, 1));
         end
      end
      @(posedge pclk);
      slot_valid <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk_drv(drive_r, exp_drv(3'h0, 0));
      // settle delay: zero, three steps, and a wait cut short by turn-off
      apb(1'b1, ba(12), 32'h0, 4'h1);
      watch(10, 0);
      chk_cyc(hit, 1);
      apb(1'b1, ba(12), 32'h3, 4'h1);
      watch(130, 0);
      chk_cyc(hit, 1 + 3 * STEP_CYC);
      watch(130, 10);
      chk_cyc(hit, -1);
      end_of_test();
   end

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #500000;
      err_count++;
      end_of_test();
   end
endmodule : edsc_bank_tb
